// ---- fll_pkg.sv ----
// Shared constants and types for the loop status and ratio link.
// Assumes both ends run on one core clock and share this package.
package fll_pkg;

    localparam int NUM_LOOPS    = 2;
    // Cycles a status change must stay stable before it is passed on
    localparam int DEB_CYCLES   = 4;

    localparam int PREDIV_W     = 2;
    localparam int OUTDIV_W     = 3;
    localparam int FRATIO_W     = 4;
    localparam int INT_W        = 10;
    localparam int FRAC_W       = 16;
    localparam int HZ_W         = 32;

    // 13.5 MHz ceiling on the divided reference
    localparam logic [HZ_W-1:0] REF_MAX_HZ = 32'h00CD_FE60;

    localparam logic [PREDIV_W-1:0] PREDIV_DIV1 = 2'h0;
    localparam logic [PREDIV_W-1:0] PREDIV_DIV2 = 2'h1;
    localparam logic [PREDIV_W-1:0] PREDIV_DIV4 = 2'h2;
    localparam logic [PREDIV_W-1:0] PREDIV_DIV8 = 2'h3;

    typedef enum logic [1:0] {
        PIN_OFF,
        PIN_CLOCK_GOOD,
        PIN_LOCKED,
        PIN_CLOCK_OUT
    } pin_func_t;

    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_GCD,
        CALC_SEND
    } calc_state_t;

    // Reference ratio factor is carried as (factor - 1)
    typedef struct packed {
        logic [PREDIV_W-1:0] ref_clock_predivider;
        logic [OUTDIV_W-1:0] output_divider;
        logic [FRATIO_W-1:0] reference_ratio_factor;
        logic [INT_W-1:0]    integer_ratio;
        logic [FRAC_W-1:0]   fraction_numerator;
        logic [FRAC_W-1:0]   fraction_denominator;
    } ratio_cfg_t;

    localparam ratio_cfg_t CFG_RESET = '0;

endpackage

// ---- fll_link_if.sv ----
// Link between the loop status device and its configuring partner.
// Assumes both ends are clocked by the same core clock.
`timescale 1ns/1ps
interface fll_link_if #(
    parameter int N = fll_pkg::NUM_LOOPS
);
    localparam int LOOP_W = (N > 1) ? $clog2(N) : 1;

    logic [N-1:0]        clock_good_raw;
    logic [N-1:0]        locked_raw;
    logic [N-1:0]        clock_good_evt;
    logic [N-1:0]        locked_evt;
    logic                debounce_clk_run;
    fll_pkg::pin_func_t  pin_func;
    logic [LOOP_W-1:0]   pin_loop;
    fll_pkg::ratio_cfg_t cfg;
    logic                cfg_valid;
    logic [LOOP_W-1:0]   cfg_loop;

    modport device (
        output clock_good_raw,
        output locked_raw,
        output clock_good_evt,
        output locked_evt,
        input  debounce_clk_run,
        input  pin_func,
        input  pin_loop,
        input  cfg,
        input  cfg_valid,
        input  cfg_loop
    );

    modport host (
        input  clock_good_raw,
        input  locked_raw,
        input  clock_good_evt,
        input  locked_evt,
        output debounce_clk_run,
        output pin_func,
        output pin_loop,
        output cfg,
        output cfg_valid,
        output cfg_loop
    );

endinterface

// ---- fll_status_device.sv ----
// Loop status end: raw and de-bounced status, pin output, ratio store.
// Assumes the partner supplies ratio settings and the filter run level.
//
// Summary of operation
// [R1] Clock-good per loop once started and clocking
// [R2] Separate lock indication per loop
// [R3] Both indications feed the interrupt logic
// [R4] Filtered copies advance only with a running clock
// [R5] Pin shows raw status, unfiltered, clockless
// [R6] Pin can carry a loop-derived clock
// [R7] Partner keeps divided reference at most 13.5MHz for sources up to 108MHz
// [R8] Partner derives oscillator and total ratio
// [R9] Integer part and fraction pair loaded separately
// [R10] Partner takes common divisor of both terms
// [R11] Numerator and denominator reduced by divisor
// [R12] Each loop programmed from its own source
// [R13] Change passed after fixed stable sample count
`timescale 1ns/1ps
module fll_status_device #(
    parameter int N          = fll_pkg::NUM_LOOPS,
    parameter int DEB_CYCLES = fll_pkg::DEB_CYCLES
) (
    input  wire logic                I_CORE_CLK,
    input  wire logic                I_RST_N,
    fll_link_if.device               LINK,
    input  wire logic [N-1:0]        I_LOOP_STARTED,
    input  wire logic [N-1:0]        I_LOOP_CLK_ACTIVE,
    input  wire logic [N-1:0]        I_LOOP_LOCK,
    input  wire logic [N-1:0]        I_LOOP_CLK,
    output logic      [N-1:0]        O_CLOCK_GOOD,
    output logic      [N-1:0]        O_LOCKED,
    output logic                     O_GPIO_PIN,
    output logic                     O_GPIO_OE,
    output fll_pkg::ratio_cfg_t      O_LOOP_CFG [N],
    output logic      [N-1:0]        O_CFG_ERR
);
    import fll_pkg::*;

    localparam int CNT_W  = $clog2(DEB_CYCLES) + 1;
    localparam int SIG_N  = 2 * N;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEB_CYCLES - 1);

    // Raw status
    wire  [N-1:0]     clock_good_raw;
    wire  [N-1:0]     locked_raw;
    wire  [SIG_N-1:0] raw_vec;
    wire              filter_run;

    // Filter state
    logic [SIG_N-1:0] filt;
    logic [CNT_W-1:0] stable_cnt [SIG_N];

    // Pin selection
    wire              sel_good;
    wire              sel_lock;
    wire              sel_clk;

    // Config checks
    wire              in_bad;

    // A loop is clock-good only once started and its output is running
    assign clock_good_raw = I_LOOP_STARTED & I_LOOP_CLK_ACTIVE;        // [R1]
    assign locked_raw     = I_LOOP_LOCK;                                // [R2]

    assign LINK.clock_good_raw = clock_good_raw;
    assign LINK.locked_raw     = locked_raw;

    assign raw_vec    = {locked_raw, clock_good_raw};
    // With neither slow nor system clock present the filter freezes,
    // so no new event can reach the interrupt logic.
    assign filter_run = LINK.debounce_clk_run;                          // [R4]

    genvar g;
    generate
        for (g = 0; g < SIG_N; g++) begin : g_deb
            wire same = (raw_vec[g] == filt[g]);
            wire done = (stable_cnt[g] == CNT_LAST);

            always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    stable_cnt[g] <= '0;
                end else if (filter_run) begin                      // [R4]
                    if (same || done) begin
                        stable_cnt[g] <= '0;
                    end else begin
                        stable_cnt[g] <= stable_cnt[g] + 1'b1;       // [R13]
                    end
                end
            end

            always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    filt[g] <= 1'b0;
                end else if (filter_run && !same && done) begin
                    filt[g] <= raw_vec[g];                           // [R13]
                end
            end
        end
    endgenerate

    // Filtered copies are the interrupt sources
    assign LINK.clock_good_evt = filt[N-1:0];                           // [R3]
    assign LINK.locked_evt     = filt[SIG_N-1:N];                       // [R3]

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_CLOCK_GOOD <= '0;
            O_LOCKED     <= '0;
        end else begin
            O_CLOCK_GOOD <= filt[N-1:0];
            O_LOCKED     <= filt[SIG_N-1:N];
        end
    end

    // The pin path bypasses every flop: it must work with no clock at
    // all, so the selected level is combinational from the raw status.
    assign sel_good = clock_good_raw[LINK.pin_loop];
    assign sel_lock = locked_raw[LINK.pin_loop];
    assign sel_clk  = I_LOOP_CLK[LINK.pin_loop];

    always_comb begin
        case (LINK.pin_func)
            PIN_CLOCK_GOOD: begin
                O_GPIO_PIN = sel_good;                                 // [R5]
                O_GPIO_OE  = 1'b1;
            end
            PIN_LOCKED: begin
                O_GPIO_PIN = sel_lock;                                 // [R5]
                O_GPIO_OE  = 1'b1;
            end
            PIN_CLOCK_OUT: begin
                O_GPIO_PIN = sel_clk;                                  // [R6]
                O_GPIO_OE  = 1'b1;
            end
            default: begin
                O_GPIO_PIN = 1'b0;
                O_GPIO_OE  = 1'b0;
            end
        endcase
    end

    // A fraction must be proper and the output divider and integer ratio nonzero;
    // bad settings are stored anyway and only flagged, since the
    // loop itself decides whether to run on them.
    assign in_bad = (LINK.cfg.fraction_denominator == '0)
                 || (LINK.cfg.fraction_numerator
                     >= LINK.cfg.fraction_denominator)
                 || (LINK.cfg.output_divider == '0)
                 || (LINK.cfg.integer_ratio == '0);                    // [R9]

    generate
        for (g = 0; g < N; g++) begin : g_cfg
            wire hit = LINK.cfg_valid && (LINK.cfg_loop == g);

            // Each loop keeps its own settings
            always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    O_LOOP_CFG[g] <= CFG_RESET;
                end else if (hit) begin
                    O_LOOP_CFG[g] <= LINK.cfg;                         // [R12]
                end
            end

            always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    O_CFG_ERR[g] <= 1'b1;
                end else if (hit) begin
                    O_CFG_ERR[g] <= in_bad;
                end
            end
        end
    endgenerate

endmodule

// ---- fll_ratio_host.sv ----
// Partner end: ratio calculation, filter run level, pin select and
// sticky interrupt flags from the filtered loop status.
// Assumes frequencies in hertz, stable while a calculation starts.
`timescale 1ns/1ps
module fll_ratio_host #(
    parameter int N = fll_pkg::NUM_LOOPS
) (
    input  wire logic                       I_CORE_CLK,
    input  wire logic                       I_RST_N,
    fll_link_if.host                        LINK,
    input  wire fll_pkg::pin_func_t         I_PIN_FUNC,
    input  wire logic [LINK.LOOP_W-1:0]     I_PIN_LOOP,
    input  wire logic                       I_CLK32_EN,
    input  wire logic                       I_SYSTEM_CLOCK_EN,
    input  wire logic                       I_CALC_START,
    input  wire logic [LINK.LOOP_W-1:0]     I_CALC_LOOP,
    input  wire logic [fll_pkg::HZ_W-1:0]   I_SOURCE_HZ,
    input  wire logic [fll_pkg::HZ_W-1:0]   I_TARGET_HZ,
    input  wire logic [fll_pkg::OUTDIV_W-1:0] I_OUTPUT_DIVIDER,
    input  wire logic [fll_pkg::FRATIO_W:0] I_RATIO_FACTOR,
    input  wire logic [2*N-1:0]             I_IRQ_CLEAR,
    output logic                            O_CALC_BUSY,
    output logic                            O_CALC_DONE,
    output logic      [2*N-1:0]             O_IRQ_PENDING,
    output logic                            O_IRQ
);
    import fll_pkg::*;

    calc_state_t             state;
    logic [HZ_W-1:0]         ref_term;
    logic [HZ_W-1:0]         vco_hz;
    logic [HZ_W-1:0]         gx;
    logic [HZ_W-1:0]         gy;
    logic [PREDIV_W-1:0]     pre_q;
    logic [OUTDIV_W-1:0]     outdiv_q;
    logic [FRATIO_W-1:0]     fratio_q;
    logic [LINK.LOOP_W-1:0]  loop_q;
    logic [2*N-1:0]          evt_prev;

    wire  [PREDIV_W-1:0]     pre_sel;
    wire  [HZ_W-1:0]         fref_hz;
    wire  [HZ_W+FRATIO_W:0]  ref_full;
    wire  [HZ_W+OUTDIV_W-1:0] vco_full;
    wire  [HZ_W-1:0]         n_full;
    wire  [2*HZ_W-1:0]       n_times_ref;
    wire  [HZ_W-1:0]         theta_full;
    wire  [HZ_W-1:0]         lambda_full;
    wire  [2*N-1:0]          evt_vec;
    wire  [2*N-1:0]          evt_rise;

    // Smallest predivider that brings the reference under the ceiling; /8 when none of /1, /2, /4 does
    assign pre_sel = (I_SOURCE_HZ <= REF_MAX_HZ)        ? PREDIV_DIV1 :
                     ((I_SOURCE_HZ >> 1) <= REF_MAX_HZ) ? PREDIV_DIV2 :
                     ((I_SOURCE_HZ >> 2) <= REF_MAX_HZ) ? PREDIV_DIV4 :
                                                          PREDIV_DIV8;  // [R7]
    // Predivider code is the shift count: /1, /2, /4, /8
    assign fref_hz  = I_SOURCE_HZ >> pre_sel;                           // [R7]
    assign ref_full = fref_hz * I_RATIO_FACTOR;
    assign vco_full = I_TARGET_HZ * I_OUTPUT_DIVIDER;                   // [R8]

    assign n_full      = vco_hz / ref_term;                             // [R8]
    assign n_times_ref = n_full * ref_term;
    assign theta_full  = (vco_hz - n_times_ref[HZ_W-1:0]) / gx;         // [R11]
    assign lambda_full = ref_term / gx;                                 // [R11]

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state    <= CALC_IDLE;
            ref_term <= '0;
            vco_hz   <= '0;
            gx       <= '0;
            gy       <= '0;
            pre_q    <= '0;
            outdiv_q <= '0;
            fratio_q <= '0;
            loop_q   <= '0;
        end else begin
            case (state)
                CALC_IDLE: begin
                    if (I_CALC_START) begin
                        // Source of the addressed loop only
                        loop_q   <= I_CALC_LOOP;                        // [R12]
                        pre_q    <= pre_sel;
                        outdiv_q <= I_OUTPUT_DIVIDER;
                        fratio_q <= FRATIO_W'(I_RATIO_FACTOR - 1'b1);
                        ref_term <= ref_full[HZ_W-1:0];
                        vco_hz   <= vco_full[HZ_W-1:0];
                        gx       <= vco_full[HZ_W-1:0];
                        gy       <= ref_full[HZ_W-1:0];
                        state    <= CALC_GCD;
                    end
                end
                CALC_GCD: begin
                    if (gy == '0) begin
                        state <= CALC_SEND;
                    end else begin
                        gx <= gy;
                        gy <= gx % gy;                                  // [R10]
                    end
                end
                CALC_SEND: begin
                    state <= CALC_IDLE;
                end
                default: begin
                    state <= CALC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            LINK.cfg       <= CFG_RESET;
            LINK.cfg_valid <= 1'b0;
            LINK.cfg_loop  <= '0;
            O_CALC_DONE    <= 1'b0;
        end else begin
            LINK.cfg_valid <= (state == CALC_SEND);
            O_CALC_DONE    <= (state == CALC_SEND);
            if (state == CALC_SEND) begin
                LINK.cfg_loop                    <= loop_q;
                LINK.cfg.ref_clock_predivider    <= pre_q;
                LINK.cfg.output_divider          <= outdiv_q;
                LINK.cfg.reference_ratio_factor  <= fratio_q;
                LINK.cfg.integer_ratio           <= n_full[INT_W-1:0];   // [R9]
                LINK.cfg.fraction_numerator      <= theta_full[FRAC_W-1:0];
                LINK.cfg.fraction_denominator    <= lambda_full[FRAC_W-1:0];
            end
        end
    end

    assign O_CALC_BUSY = (state != CALC_IDLE);

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            LINK.debounce_clk_run <= 1'b0;
            LINK.pin_func         <= PIN_OFF;
            LINK.pin_loop         <= '0;
        end else begin
            LINK.debounce_clk_run <= I_CLK32_EN | I_SYSTEM_CLOCK_EN;
            LINK.pin_func         <= I_PIN_FUNC;
            LINK.pin_loop         <= I_PIN_LOOP;
        end
    end

    // A rising filtered level raises a flag; set beats clear
    assign evt_vec  = {LINK.locked_evt, LINK.clock_good_evt};
    assign evt_rise = evt_vec & ~evt_prev;

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            evt_prev      <= '0;
            O_IRQ_PENDING <= '0;
        end else begin
            evt_prev      <= evt_vec;
            O_IRQ_PENDING <= (O_IRQ_PENDING & ~I_IRQ_CLEAR) | evt_rise;
        end
    end

    assign O_IRQ = |O_IRQ_PENDING;

endmodule

// ---- fll_link_properties.sv ----
// Checker for the loop status link, watching the interface signals only.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module fll_link_properties #(
    parameter int N      = 2,
    parameter int LOOP_W = 1
) (
    input wire logic                I_CORE_CLK,
    input wire logic                I_RST_N,
    input wire logic [N-1:0]        clock_good_raw,
    input wire logic [N-1:0]        locked_raw,
    input wire logic [N-1:0]        clock_good_evt,
    input wire logic [N-1:0]        locked_evt,
    input wire logic                debounce_clk_run,
    input wire fll_pkg::pin_func_t  pin_func,
    input wire logic [LOOP_W-1:0]   pin_loop,
    input wire fll_pkg::ratio_cfg_t cfg,
    input wire logic                cfg_valid,
    input wire logic [LOOP_W-1:0]   cfg_loop
);
    import fll_pkg::*;

    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_N);

    property p_cg_freeze;
        !debounce_clk_run |=> $stable(clock_good_evt);
    endproperty
    a_cg_freeze: assert property (p_cg_freeze)
        else $error("clock good status moved while filter stopped");

    property p_lk_freeze;
        !debounce_clk_run |=> $stable(locked_evt);
    endproperty
    a_lk_freeze: assert property (p_lk_freeze)
        else $error("lock status moved while filter stopped");

    // Four running samples of a changed level must pass it on
    property p_cg_fill;
        (clock_good_raw[0] && debounce_clk_run && !clock_good_evt[0]) [*4] |=> clock_good_evt[0];
    endproperty
    a_cg_fill: assert property (p_cg_fill)
        else $error("clock good not passed after stable samples");

    property p_cg_rise;
        $rose(clock_good_evt[0]) |-> $past(clock_good_raw[0]) && $past(clock_good_raw[0], 2)
            && $past(clock_good_raw[0], 3) && $past(clock_good_raw[0], 4);
    endproperty
    a_cg_rise: assert property (p_cg_rise)
        else $error("clock good passed before being stable");

    property p_lk_fill;
        (!locked_raw[1] && debounce_clk_run && locked_evt[1]) [*4] |=> !locked_evt[1];
    endproperty
    a_lk_fill: assert property (p_lk_fill)
        else $error("lock loss not passed after stable samples");

    property p_valid_pulse;
        cfg_valid |=> !cfg_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("settings valid longer than one cycle");

    property p_cfg_hold;
        !cfg_valid |-> $stable({cfg, cfg_loop});
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("settings changed without valid");

    property p_frac;
        cfg_valid |-> cfg.fraction_numerator < cfg.fraction_denominator;
    endproperty
    a_frac: assert property (p_frac)
        else $error("fraction numerator not below denominator");

endmodule

// ---- fll_status_and_ratio_config_tb.sv ----
// Bench joining the status device and the ratio host through the link.
// Assumes the package and the link interface are compiled first.
`timescale 1ns/1ps
module fll_status_and_ratio_config_tb;
    import fll_pkg::*;

    typedef struct {
        int         loop;
        ratio_cfg_t cfg;
    } note_t;

    logic        clk;
    logic        rst_n;
    logic [1:0]  started, active, lock, lclk, clock_good, locked, cfg_err;
    logic        gpio_pin, gpio_oe, clk32_en, system_clock_en, calc_start, calc_busy, calc_done;
    logic        pin_loop, calc_loop, irq;
    pin_func_t   pin_func;
    ratio_cfg_t  loop_cfg [2];
    logic [31:0] source_hz, target_hz, seed;
    logic [2:0]  out_div;
    logic [4:0]  ratio_factor;
    logic [3:0]  irq_clear, irq_pending;
    note_t       exp_q [$];
    int          num_errors = 0;
    int          checked = 0;

    fll_link_if #(.N(2)) link ();

    fll_status_device u_fll_status_device (.I_CORE_CLK(clk), .I_RST_N(rst_n), .LINK(link),
        .I_LOOP_STARTED(started), .I_LOOP_CLK_ACTIVE(active), .I_LOOP_LOCK(lock),
        .I_LOOP_CLK(lclk), .O_CLOCK_GOOD(clock_good), .O_LOCKED(locked), .O_GPIO_PIN(gpio_pin),
        .O_GPIO_OE(gpio_oe), .O_LOOP_CFG(loop_cfg), .O_CFG_ERR(cfg_err));

    fll_ratio_host u_fll_ratio_host (.I_CORE_CLK(clk), .I_RST_N(rst_n), .LINK(link),
        .I_PIN_FUNC(pin_func), .I_PIN_LOOP(pin_loop), .I_CLK32_EN(clk32_en),
        .I_SYSTEM_CLOCK_EN(system_clock_en), .I_CALC_START(calc_start), .I_CALC_LOOP(calc_loop),
        .I_SOURCE_HZ(source_hz), .I_TARGET_HZ(target_hz), .I_OUTPUT_DIVIDER(out_div),
        .I_RATIO_FACTOR(ratio_factor), .I_IRQ_CLEAR(irq_clear), .O_CALC_BUSY(calc_busy),
        .O_CALC_DONE(calc_done), .O_IRQ_PENDING(irq_pending), .O_IRQ(irq));

    fll_link_properties #(.N(2), .LOOP_W(1)) u_fll_link_properties (.I_CORE_CLK(clk),
        .I_RST_N(rst_n), .clock_good_raw(link.clock_good_raw), .locked_raw(link.locked_raw),
        .clock_good_evt(link.clock_good_evt), .locked_evt(link.locked_evt),
        .debounce_clk_run(link.debounce_clk_run), .pin_func(link.pin_func),
        .pin_loop(link.pin_loop), .cfg(link.cfg), .cfg_valid(link.cfg_valid),
        .cfg_loop(link.cfg_loop));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(string what, logic [63:0] exp, logic [63:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic ratio_cfg_t expect_cfg(longint src, longint tgt, int od, int fr);
        ratio_cfg_t c;
        longint     fref, fvco, den, n, a, b, t;
        int         k;
        k = 0;
        fref = src;
        while (fref > REF_MAX_HZ) begin
            k = k + 1;
            fref = src >> k;
        end
        fvco = tgt * od;
        den = fr * fref;
        n = fvco / den;
        a = den;
        b = fvco;
        while (b != 0) begin
            t = a % b;
            a = b;
            b = t;
        end
        c.ref_clock_predivider = PREDIV_W'(k);
        c.output_divider = OUTDIV_W'(od);
        c.reference_ratio_factor = FRATIO_W'(fr - 1);
        c.integer_ratio = INT_W'(n);
        c.fraction_numerator = FRAC_W'((fvco - n * den) / a);
        c.fraction_denominator = FRAC_W'(den / a);
        return c;
    endfunction

    task automatic run_calc(logic [31:0] src, logic [31:0] tgt, int od, int fr, logic lp);
        note_t nt;
        int    w;
        nt.loop = int'(lp);
        nt.cfg = expect_cfg(src, tgt, od, fr);
        exp_q.push_back(nt);
        source_hz = src;
        target_hz = tgt;
        out_div = 3'(od);
        ratio_factor = 5'(fr);
        calc_loop = lp;
        calc_start = 1'b1;
        tick(1);
        calc_start = 1'b0;
        check("calc busy", 1, calc_busy);
        w = 0;
        while (calc_done !== 1'b1 && w < 2000) begin
            tick(1);
            w++;
        end
        check("calc done", 1, w < 2000);
        tick(3);
    endtask

    // Each stored result is matched against the oldest expectation
    initial forever begin
        note_t nt;
        @(posedge clk);
        #2;
        if (link.cfg_valid === 1'b1) begin
            nt = exp_q.pop_front();
            check("link cfg", nt.cfg, link.cfg);
            @(posedge clk);
            #2;
            check("stored cfg", nt.cfg, loop_cfg[nt.loop]);
            check("cfg error", 0, cfg_err[nt.loop]);
        end
    end

    initial begin
        #3_000_000;
        num_errors++;
        $display("[FAIL] watchdog expected done seen hang");
        complete_run();
    end

    initial begin
        logic ep;
        rst_n = 1'b0;
        {started, active, lock, lclk, clk32_en, system_clock_en, calc_start} = '0;
        {pin_loop, calc_loop, source_hz, target_hz, out_div, ratio_factor, irq_clear} = '0;
        pin_func = PIN_OFF;
        seed = 32'h0001_4D34;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // Filter clocks stay off here, so the pin must follow raw status
        for (int f = 0; f < 4; f++) begin
            for (int l = 0; l < 2; l++) begin
                pin_func = pin_func_t'(f[1:0]);
                pin_loop = l[0];
                tick(2);
                seed = lfsr_next(seed);
                {lclk, lock, active, started} = seed[7:0];
                #2;
                ep = (f == 1) ? started[l] & active[l] : (f == 2) ? lock[l] : (f == 3) ? lclk[l] : 1'b0;
                check("gpio pin", ep, gpio_pin);
                check("gpio oe", f != 0, gpio_oe);
                check("good raw", started & active, link.clock_good_raw);
                check("lock raw", lock, link.locked_raw);
            end
        end
        {started, active, lock} = '0;
        tick(2);
        {started, active} = 4'h5;
        tick(10);
        check("good held", 2'h0, clock_good);
        system_clock_en = 1'b1;
        tick(8);
        check("good passed", 2'h1, clock_good);
        check("irq good", 4'h1, irq_pending);
        lock = 2'h2;
        tick(3);
        lock = 2'h0;
        tick(8);
        check("lock glitch", 2'h0, locked);
        system_clock_en = 1'b0;
        clk32_en = 1'b1;
        lock = 2'h2;
        tick(8);
        check("lock passed", 2'h2, locked);
        check("irq lock", 4'h9, irq_pending);
        check("irq out", 1, irq);
        irq_clear = 4'hF;
        tick(1);
        irq_clear = 4'h0;
        tick(1);
        check("irq clear", 5'h00, {irq, irq_pending});
        clk32_en = 1'b0;
        tick(2);
        {started, lock} = '0;
        tick(8);
        check("frozen", 4'h9, {locked, clock_good});
        clk32_en = 1'b1;
        tick(8);
        check("released", 4'h0, {locked, clock_good});
        run_calc(32'h00B7_1B00, 32'h02EE_0000, 2, 1, 1'b0);
        run_calc(32'h019B_FCC0, 32'h02EE_0000, 2, 1, 1'b1);
        run_calc(32'h0000_BB80, 32'h02EE_0000, 2, 15, 1'b0);
        run_calc(32'h0000_8000, 32'h0177_0000, 4, 16, 1'b1);
        run_calc(32'h02DC_6C00, 32'h02EE_0000, 2, 1, 1'b0);
        run_calc(32'h05B8_D800, 32'h02EE_0000, 2, 1, 1'b1);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            run_calc((32'h10 + seed % 32'hD20) * 32'h1F40, 32'h02EE_0000, 2, 1, seed[5]);
        end
        check("queue empty", 0, exp_q.size());
        complete_run();
    end

endmodule
